// [ppfm_params.svh]
// Register map, masks and reset values of the port pin function mux
`ifndef PPFM_PARAMS_SVH
`define PPFM_PARAMS_SVH

// Register groups, byte address bits [7:5]; port index in bits [4:2]
`define PPFM_GRP_DATA 3'h0
`define PPFM_GRP_DIR 3'h1
`define PPFM_GRP_ALT 3'h2
`define PPFM_GRP_PIN 3'h3
`define PPFM_GRP_CTRL 3'h4

// Byte address of each group base
`define PPFM_DATA_BASE 32'h0000_0000
`define PPFM_DIR_BASE 32'h0000_0020
`define PPFM_ALT_BASE 32'h0000_0040
`define PPFM_PIN_BASE 32'h0000_0060
`define PPFM_CTRL_ADDR 32'h0000_0080

// Reset values
`define PPFM_RST_BYTE 8'h00
`define PPFM_RST_RATE 2'h0

// Alternate select bits that exist, ports 7..0
`define PPFM_ALT_VALID 64'hfcff_ffff_ffff_0000
// Outputs released by the float pin, ports 7..0
`define PPFM_FLOAT_MASK 64'hf000_0000_0fff_ffff
// Alternate directions of port 5, bit 7..0
`define PPFM_P5_ALT_OE 8'h5e

`endif

// [ppfm_pkg.sv]
// Types shared by the port pin function mux
package ppfm_pkg;

   typedef logic [7:0] ppfm_byte_t;

   typedef enum logic [1:0] {
      PPFM_DIV2,
      PPFM_DIV4,
      PPFM_DIV8,
      PPFM_DIV16
   } ppfm_rate_t;

endpackage

// [ppfm_port_mux.sv]
// Pin function mux and port control for ports 0 to 7
// Summary of operation
// - Per-bit direction register for each 8-bit port
// - Alternate select overrides direction per bit
// - Program select low: port 0 is bus
// - Port 1 drives upper address on data access
// - Reset and init make all pins inputs; events spare forced bus pins
// - Float pin releases ports 0, 1, 2
// - Float releases port 3 low, port 7 high
// - Port 2 alternates carry timer match outputs
// - Port 3 bit 0 match out or capture in
// - Port 3 bits 1-3 only in four-pin mode
// - Port 3 bits 4-7 feed capture inputs
// - Port 4 alternates feed transition detectors
// - Port 5 alternates carry FIFO serial port
// - Port 5 bit 6 outputs selected divided clock
// - Port 6 carries interrupts and serial data
// - Serial 1 shift clocks follow master mode
// - Port 7 bit 2 address latch strobe
// - Port 7 bit 3 program read strobe
// - Strobes pulled up in external init
// - Port 7 bits 2-7 alternates, PWM outputs
//
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "ppfm_params.svh"

module ppfm_port_mux
   import ppfm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Control pins
   input  wire logic        external_program_select_n,
   input  wire logic        chip_init_pin_n,
   input  wire logic        output_float_pin,
   // Internal reset events
   input  wire logic        break_instruction,
   input  wire logic        watchdog_overflow,
   input  wire logic        opcode_trap,
   // Port pins 0..7, port p in bits [8p+7:8p]
   input  wire logic [63:0] pin_in,
   output logic      [63:0] pin_out,
   output logic      [63:0] pin_oe,
   output logic             strobe_pullup,
   // External bus
   input  wire logic [7:0]  muxed_low_bus_out,
   input  wire logic        muxed_low_bus_oe,
   output logic      [7:0]  muxed_low_bus_in,
   input  wire logic        external_data_access,
   input  wire logic [7:0]  upper_address_bits,
   input  wire logic        address_latch_strobe,
   input  wire logic        program_read_strobe,
   // Timer
   input  wire logic [7:0]  match_output_pin,
   input  wire logic        timer_seventeen_pin_a,
   input  wire logic [2:0]  timer_seventeen_pins_bcd,
   input  wire logic        edge_latch_mode,
   input  wire logic        four_pin_match_mode,
   output logic             timer_seventeen_capture,
   output logic      [3:0]  edge_latch_pin,
   // Transition detectors
   output logic      [7:0]  transition_input,
   // FIFO serial port
   output logic             fifo_serial_in,
   input  wire logic        fifo_serial_out,
   input  wire logic        fifo_serial_clock,
   input  wire logic        fifo_read_write,
   input  wire logic        fifo_select,
   output logic             dual_irq_two,
   output logic             fifo_busy,
   // Interrupts and UARTs
   output logic      [1:0]  external_irq,
   output logic             serial0_receive_data,
   input  wire logic        serial0_transmit_data,
   output logic             serial1_receive_data,
   input  wire logic        serial1_transmit_data,
   input  wire logic        serial1_rx_master,
   input  wire logic        serial1_tx_master,
   input  wire logic        serial1_receive_shift_clock_out,
   input  wire logic        serial1_transmit_shift_clock_out,
   output logic             serial1_receive_shift_clock_in,
   output logic             serial1_transmit_shift_clock_in,
   // PWM
   input  wire logic [3:0]  pulse_width_channel
);

   localparam logic [63:0] ALT_VALID = `PPFM_ALT_VALID;
   localparam logic [63:0] FLOAT_MASK = `PPFM_FLOAT_MASK;

   ppfm_byte_t port_data [8];
   ppfm_byte_t port_direction_reg [8];
   ppfm_byte_t port_alt_select_reg [8];
   ppfm_rate_t peripheral_control_reg;

   logic [63:0] pin_meta;
   logic [63:0] pin_sync;
   logic [2:0]  ctl_meta;
   logic [2:0]  ctl_sync;
   logic [3:0]  div_cnt;
   logic        div_clk;

   // Divider mask: toggle every 2^rate cycles
   function automatic logic [3:0] rate_mask(input ppfm_rate_t r);
      logic [3:0] m;
      m = 4'h0;
      unique case (r)
         PPFM_DIV2:  m = 4'h0;
         PPFM_DIV4:  m = 4'h1;
         PPFM_DIV8:  m = 4'h3;
         PPFM_DIV16: m = 4'h7;
      endcase
      return m;
   endfunction

   // Synchronisers; first stage read only by second
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_meta <= 64'h0;
         pin_sync <= 64'h0;
         ctl_meta <= 3'h6;
         ctl_sync <= 3'h6;
      end else begin
         pin_meta <= pin_in;
         pin_sync <= pin_meta;
         ctl_meta <= {external_program_select_n,
                      chip_init_pin_n, output_float_pin};
         ctl_sync <= ctl_meta;
      end
   end

   wire ext_prog_low = ~ctl_sync[2];
   wire init_low = ~ctl_sync[1];
   wire float_s = ctl_sync[0];
   // Any of these sources clears every register
   wire soft_clr = init_low | break_instruction
                 | watchdog_overflow | opcode_trap;

   // Bus decode
   wire       wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire [2:0] grp = wb_adr_i[7:5];
   wire [2:0] idx = wb_adr_i[4:2];
   wire [7:0] wr_byte = wb_dat_i[7:0];
   wire       upper_ok = (wb_adr_i[31:8] == 24'h0)
                       & (wb_adr_i[1:0] == 2'h0);
   wire       ctrl_hit = (grp == `PPFM_GRP_CTRL) & (idx == 3'h0);
   wire       map_hit = upper_ok & ((grp < `PPFM_GRP_CTRL) | ctrl_hit);
   wire       wb_wr = wb_req & wb_we_i & wb_sel_i[0] & map_hit;
   wire       pin_grp = grp == `PPFM_GRP_PIN;
   wire [7:0] alt_ok = ALT_VALID[8*idx +: 8];

   // Register file; reset sources beat a write in the same cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 8; i++) begin
            port_data[i] <= `PPFM_RST_BYTE;
            port_direction_reg[i] <= `PPFM_RST_BYTE;
            port_alt_select_reg[i] <= `PPFM_RST_BYTE;
         end
         peripheral_control_reg <= ppfm_rate_t'(`PPFM_RST_RATE);
      end else if (soft_clr) begin
         for (int i = 0; i < 8; i++) begin
            port_data[i] <= `PPFM_RST_BYTE;
            port_direction_reg[i] <= `PPFM_RST_BYTE;
            port_alt_select_reg[i] <= `PPFM_RST_BYTE;
         end
         peripheral_control_reg <= ppfm_rate_t'(`PPFM_RST_RATE);
      end else if (wb_wr) begin
         if (grp == `PPFM_GRP_DATA)
            port_data[idx] <= wr_byte;
         if (grp == `PPFM_GRP_DIR)
            port_direction_reg[idx] <= wr_byte;
         if (grp == `PPFM_GRP_ALT)
            port_alt_select_reg[idx] <= wr_byte & alt_ok;
         if (ctrl_hit)
            peripheral_control_reg <= ppfm_rate_t'(wr_byte[1:0]);
      end
   end

   // Read data
   wire [7:0] rd_data = port_data[idx];
   wire [7:0] rd_dir = port_direction_reg[idx];
   wire [7:0] rd_alt = port_alt_select_reg[idx];
   wire [7:0] rd_pin = pin_sync[8*idx +: 8];
   wire [7:0] rd_ctrl = {6'h0, peripheral_control_reg};
   wire [7:0] rd_byte = !map_hit ? 8'h00 :
                        grp == `PPFM_GRP_DATA ? rd_data :
                        grp == `PPFM_GRP_DIR ? rd_dir :
                        grp == `PPFM_GRP_ALT ? rd_alt :
                        pin_grp ? rd_pin : rd_ctrl;

   // Every access acks one cycle later; unmapped reads give zero
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req)
            wb_dat_o <= {24'h0, rd_byte};
      end
   end

   // Clock output divider
   wire [3:0] div_mask = rate_mask(peripheral_control_reg);
   wire       div_tick = (div_cnt & div_mask) == div_mask;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_cnt <= 4'h0;
         div_clk <= 1'b0;
      end else begin
         div_cnt <= div_cnt + 4'h1;
         if (div_tick)
            div_clk <= ~div_clk;
      end
   end

   // Flattened registers
   logic [63:0] data_v;
   logic [63:0] dir_v;
   logic [63:0] alt_v;

   for (genvar g = 0; g < 8; g++) begin : g_flat
      assign data_v[8*g +: 8] = port_data[g];
      assign dir_v[8*g +: 8] = port_direction_reg[g];
      assign alt_v[8*g +: 8] = port_alt_select_reg[g];
   end

   // Alternate outputs per port
   wire [7:0] p2_alt_out = match_output_pin;
   wire [7:0] p3_alt_out = {4'h0, timer_seventeen_pins_bcd,
                            timer_seventeen_pin_a};
   wire [7:0] p5_alt_out = {1'b0, div_clk, 1'b0, fifo_select,
                            fifo_read_write, fifo_serial_clock,
                            fifo_serial_out, 1'b0};
   wire [7:0] p6_alt_out = {serial0_transmit_data, 1'b0,
                            serial1_transmit_shift_clock_out,
                            serial1_receive_shift_clock_out,
                            serial1_transmit_data, 3'h0};
   wire [7:0] p7_alt_out = {pulse_width_channel,
                            program_read_strobe,
                            address_latch_strobe, 2'h0};

   // Alternate directions per port
   wire [7:0] p2_alt_oe = 8'hff;
   // Capture mode turns bit 0 into an input
   wire [7:0] p3_alt_oe = {4'h0, {3{four_pin_match_mode}},
                           ~edge_latch_mode};
   wire [7:0] p5_alt_oe = `PPFM_P5_ALT_OE;
   wire [7:0] p6_alt_oe = {1'b1, 1'b0, serial1_tx_master,
                           serial1_rx_master, 1'b1, 3'h0};
   wire [7:0] p7_alt_oe = 8'hfc;

   wire [63:0] alt_out = {p7_alt_out, p6_alt_out, p5_alt_out,
                          8'h00, p3_alt_out, p2_alt_out, 16'h0};
   wire [63:0] alt_oe = {p7_alt_oe, p6_alt_oe, p5_alt_oe,
                         8'h00, p3_alt_oe, p2_alt_oe, 16'h0};

   // Functions forced by the program select pin
   wire        p1_force = ext_prog_low & external_data_access;
   wire [63:0] force_en = {4'h0, {2{ext_prog_low}}, 2'h0, 40'h0,
                           {8{p1_force}}, {8{ext_prog_low}}};
   wire [63:0] force_out = {4'h0, program_read_strobe,
                            address_latch_strobe, 2'h0,
                            40'h0, upper_address_bits,
                            muxed_low_bus_out};
   wire [63:0] force_oe = {4'h0, 2'h3, 2'h0, 40'h0, 8'hff,
                           {8{muxed_low_bus_oe}}};

   // Alternate select wins over direction
   wire [63:0] sel_out = (alt_v & alt_out) | (~alt_v & data_v);
   wire [63:0] sel_oe = (alt_v & alt_oe) | (~alt_v & dir_v);
   wire [63:0] mux_out = (force_en & force_out)
                       | (~force_en & sel_out);
   wire [63:0] mux_oe = (force_en & force_oe)
                       | (~force_en & sel_oe);
   // Float only releases the listed outputs
   wire [63:0] float_v = FLOAT_MASK & {64{float_s}};
   wire [63:0] next_oe = init_low ? 64'h0 : (mux_oe & ~float_v);
   wire [63:0] next_out = mux_out;
   // Pull-up keeps the strobes inactive while the bus is idle in init
   wire        next_pullup = ext_prog_low & init_low;

   // Registered pin drive costs one cycle of latency on all paths
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_out <= 64'h0;
         pin_oe <= 64'h0;
         strobe_pullup <= 1'b0;
      end else begin
         pin_out <= next_out;
         pin_oe <= next_oe;
         strobe_pullup <= next_pullup;
      end
   end

   // Pin levels delivered to peripherals, all synchronised
   assign muxed_low_bus_in = pin_sync[7:0];
   assign timer_seventeen_capture = pin_sync[24];
   assign edge_latch_pin = pin_sync[31:28];
   assign transition_input = pin_sync[39:32];
   assign fifo_serial_in = pin_sync[40];
   assign dual_irq_two = pin_sync[45];
   assign fifo_busy = pin_sync[47];
   assign external_irq = pin_sync[49:48];
   assign serial1_receive_data = pin_sync[50];
   assign serial1_receive_shift_clock_in = pin_sync[52];
   assign serial1_transmit_shift_clock_in = pin_sync[53];
   assign serial0_receive_data = pin_sync[54];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_init_all_hiz: assert property (
      init_low |=> pin_oe == 64'h0)
      else $error("pin driven during init");

   a_dir_write: assert property (
      wb_wr && grp == `PPFM_GRP_DIR && !soft_clr
      |=> port_direction_reg[$past(idx)] == $past(wr_byte))
      else $error("direction write lost");

   a_alt_cleared: assert property (
      soft_clr |=> alt_v == 64'h0 && dir_v == 64'h0)
      else $error("select bits survive reset");

   a_alt_over_dir: assert property (
      alt_v[32] && dir_v[32] && !init_low |=> !pin_oe[32])
      else $error("direction not overridden");

   a_bus_port0: assert property (
      ext_prog_low && !init_low && !float_s
      |=> pin_out[7:0] == $past(muxed_low_bus_out)
          && pin_oe[7:0] == {8{$past(muxed_low_bus_oe)}})
      else $error("port 0 not bus");

   a_upper_addr: assert property (
      p1_force && !init_low && !float_s
      |=> pin_out[15:8] == $past(upper_address_bits)
          && pin_oe[15:8] == 8'hff)
      else $error("upper address not driven");

   a_float_group: assert property (
      float_s |=> (pin_oe & FLOAT_MASK) == 64'h0)
      else $error("float group still driven");

   a_float_free: assert property (
      float_s && !init_low && dir_v[31] && !alt_v[31]
      |=> pin_oe[31])
      else $error("port 3 high bit floated");

   a_strobe_pull: assert property (
      ext_prog_low && init_low |=> strobe_pullup)
      else $error("strobe pull-up missing");

   a_clock_pin: assert property (
      alt_v[46] && !init_low |=> pin_out[46] == $past(div_clk)
      && pin_oe[46])
      else $error("clock pin wrong");

   a_wb_ack: assert property (
      wb_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack timing wrong");

endmodule

// [ppfm_pin_env.sv]
// Pin environment model: pads, pull-ups and external drivers
`timescale 1ns/1ps

module ppfm_pin_env (
   input  wire logic [63:0] pin_out,
   input  wire logic [63:0] pin_oe,
   input  wire logic        strobe_pullup,
   input  wire logic [63:0] ext_level,
   output logic      [63:0] pin_in
);
   // Released pads show the outside driver, which the bench keeps changing, or the strobe pull-up on bits 58 and 59
   always_comb begin
      for (int i = 0; i < 64; i++) begin
         if (pin_oe[i])
            pin_in[i] = pin_out[i];
         else if (strobe_pullup && (i == 58 || i == 59))
            pin_in[i] = 1'b1;
         else
            pin_in[i] = ext_level[i];
      end
   end
endmodule

// [port_pin_function_mux_tb.sv]
// Self-checking bench for the port pin function mux
`timescale 1ns/1ps
`include "ppfm_params.svh"

module port_pin_function_mux_tb;
   import ppfm_pkg::*;
   logic        clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, strobe_pullup;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
   logic [3:0]  wb_sel_i, edge_latch_pin, pulse_width_channel;
   logic        external_program_select_n, chip_init_pin_n, output_float_pin;
   logic        break_instruction, watchdog_overflow, opcode_trap;
   logic [63:0] pin_in, pin_out, pin_oe, ext_level;
   logic [7:0]  muxed_low_bus_out, muxed_low_bus_in, upper_address_bits;
   logic [7:0]  match_output_pin, transition_input;
   logic        muxed_low_bus_oe, external_data_access, address_latch_strobe;
   logic        program_read_strobe, timer_seventeen_pin_a, timer_seventeen_capture;
   logic [2:0]  timer_seventeen_pins_bcd;
   logic        edge_latch_mode, four_pin_match_mode, fifo_serial_in, fifo_serial_out;
   logic        fifo_serial_clock, fifo_read_write, fifo_select, dual_irq_two, fifo_busy;
   logic [1:0]  external_irq;
   logic        serial0_receive_data, serial0_transmit_data, serial1_receive_data;
   logic        serial1_transmit_data, serial1_rx_master, serial1_tx_master;
   logic        serial1_receive_shift_clock_out, serial1_transmit_shift_clock_out;
   logic        serial1_receive_shift_clock_in, serial1_transmit_shift_clock_in;
   int          miscompares, checked;
   int          dir_m[8], dat_m[8], alt_m[8];

   ppfm_port_mux ppfm_port_mux_inst (.*);
   ppfm_pin_env ppfm_pin_env_inst (.*);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // About 1000 cycles are needed; the 25000-cycle limit leaves ample margin
   initial begin
      #1000000;
      miscompares++;
      complete_run();
   end

   task automatic complete_run();
      $display("Counts: checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic cmp(string what, logic [63:0] exp, logic [63:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wb(logic we, logic [31:0] adr, logic [31:0] wd, output logic [31:0] rd);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      wb_sel_i <= 4'hf;
      // No local limit: only the watchdog ends a hung wait
      do begin
         @(posedge clk);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(logic [31:0] a, logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask

   task automatic rdc(string what, logic [31:0] a, logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 32'h0, r);
      cmp(what, 64'(e), 64'(r));
   endtask

   task automatic clear_model();
      dir_m = '{default: 0};
      dat_m = '{default: 0};
      alt_m = '{default: 0};
   endtask

   task automatic set_port(int p, logic [7:0] d, logic [7:0] r, logic [7:0] a);
      logic [63:0] vm;
      vm = `PPFM_ALT_VALID;
      // Bus strobe bits of port 7 stay plain while program select is high
      a = a & vm[8*p +: 8] & ((p == 7) ? 8'hf3 : 8'hff);
      wr(`PPFM_DATA_BASE + 32'(4*p), 32'(d));
      wr(`PPFM_DIR_BASE + 32'(4*p), 32'(r));
      wr(`PPFM_ALT_BASE + 32'(4*p), 32'(a));
      dat_m[p] = d;
      dir_m[p] = r;
      alt_m[p] = a;
   endtask

   task automatic rand_inputs();
      {muxed_low_bus_out, muxed_low_bus_oe, external_data_access, upper_address_bits,
       address_latch_strobe, program_read_strobe, match_output_pin, timer_seventeen_pin_a,
       timer_seventeen_pins_bcd, edge_latch_mode, four_pin_match_mode, fifo_serial_out,
       fifo_serial_clock, fifo_read_write, fifo_select, serial0_transmit_data,
       serial1_transmit_data, serial1_rx_master, serial1_tx_master,
       serial1_receive_shift_clock_out, serial1_transmit_shift_clock_out,
       pulse_width_channel} <= 48'({$urandom, $urandom});
      ext_level <= {$urandom, $urandom};
   endtask

   task automatic check_pins(string what);
      logic [63:0] al, ao, av, dr, dv, eoe, ev, vm;
      logic        ext_low;
      // Control pins need three edges, synchronised readback two more
      repeat (6) @(posedge clk);
      for (int p = 0; p < 8; p++) begin
         al[8*p +: 8] = 8'(alt_m[p]);
         dr[8*p +: 8] = 8'(dir_m[p]);
         dv[8*p +: 8] = 8'(dat_m[p]);
      end
      ao = {8'hf0, 2'b10, serial1_tx_master, serial1_rx_master, 4'h8, 8'h5e, 8'h00,
            4'h0, {3{four_pin_match_mode}}, ~edge_latch_mode, 8'hff, 16'h0};
      av = {pulse_width_channel, 4'h0, serial0_transmit_data, 1'b0,
            serial1_transmit_shift_clock_out, serial1_receive_shift_clock_out,
            serial1_transmit_data, 6'h0, fifo_select, fifo_read_write, fifo_serial_clock,
            fifo_serial_out, 13'h0, timer_seventeen_pins_bcd, timer_seventeen_pin_a,
            match_output_pin, 16'h0};
      eoe = (al & ao) | (~al & dr);
      ev = (al & av) | (~al & dv);
      ext_low = ~external_program_select_n;
      if (ext_low) begin
         eoe[7:0] = {8{muxed_low_bus_oe}};
         ev[7:0] = muxed_low_bus_out;
         if (external_data_access) begin
            eoe[15:8] = 8'hff;
            ev[15:8] = upper_address_bits;
         end
         eoe[59:58] = 2'b11;
         ev[59:58] = {program_read_strobe, address_latch_strobe};
      end
      if (output_float_pin)
         eoe = eoe & ~`PPFM_FLOAT_MASK;
      if (!chip_init_pin_n)
         eoe = 64'h0;
      vm = eoe & ~(64'h1 << 46);
      cmp({what, " oe"}, eoe, pin_oe);
      cmp({what, " out"}, ev & vm, pin_out & vm);
      cmp({what, " pullup"}, 64'(ext_low & ~chip_init_pin_n), 64'(strobe_pullup));
      cmp({what, " inputs"}, {pin_in[39:28], pin_in[24], pin_in[7:0], pin_in[54:52],
          pin_in[50:47], pin_in[45], pin_in[40]}, {transition_input, edge_latch_pin,
          timer_seventeen_capture, muxed_low_bus_in, serial0_receive_data,
          serial1_transmit_shift_clock_in, serial1_receive_shift_clock_in,
          serial1_receive_data, external_irq, fifo_busy, dual_irq_two,
          fifo_serial_in});
   endtask

   initial begin
      sys_rst = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      {external_program_select_n, chip_init_pin_n, output_float_pin} = 3'b110;
      {break_instruction, watchdog_overflow, opcode_trap} = 3'b000;
      miscompares = 0;
      checked = 0;
      clear_model();
      void'($urandom(12));
      rand_inputs();
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      for (int p = 0; p < 8; p++) begin
         rdc("dir reset", `PPFM_DIR_BASE + 32'(4*p), 32'h0);
         rdc("alt reset", `PPFM_ALT_BASE + 32'(4*p), 32'h0);
      end
      check_pins("reset");
      $display("Test reset done");
      for (int k = 0; k < 6; k++) begin
         rand_inputs();
         for (int p = 0; p < 8; p++)
            set_port(p, 8'($urandom), 8'($urandom), (k < 2) ? 8'h0 : 8'($urandom));
         for (int p = 0; p < 8; p++)
            rdc("alt read", `PPFM_ALT_BASE + 32'(4*p), 32'(alt_m[p]));
         check_pins("ports");
         output_float_pin <= 1'b1;
         check_pins("float");
         output_float_pin <= 1'b0;
      end
      $display("Test ports done");
      external_program_select_n <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         rand_inputs();
         output_float_pin <= k[0];
         check_pins("bus");
      end
      output_float_pin <= 1'b0;
      chip_init_pin_n <= 1'b0;
      clear_model();
      check_pins("init");
      rdc("dir init", `PPFM_DIR_BASE + 32'h1c, 32'h0);
      chip_init_pin_n <= 1'b1;
      external_program_select_n <= 1'b1;
      check_pins("init off");
      $display("Test bus done");
      for (int i = 0; i < 3; i++) begin
         for (int p = 0; p < 8; p++)
            set_port(p, 8'($urandom), 8'($urandom), 8'($urandom));
         {opcode_trap, watchdog_overflow, break_instruction} <= 3'(1 << i);
         @(posedge clk);
         {opcode_trap, watchdog_overflow, break_instruction} <= 3'b000;
         clear_model();
         check_pins("event");
         rdc("alt event", `PPFM_ALT_BASE + 32'h8, 32'h0);
      end
      $display("Test events done");
      for (int r = 0; r < 4; r++) begin
         wr(`PPFM_CTRL_ADDR, 32'(r));
         rdc("rate", `PPFM_CTRL_ADDR, 32'(r));
      end
      rdc("unmapped", 32'h0000_0100, 32'h0);
      rdc("pin read", `PPFM_PIN_BASE + 32'h10, 32'(pin_in[39:32]));
      $display("Test map done");
      complete_run();
   end
endmodule
